/* File: design/omc_regs.svh */
`ifndef OMC_REGS_SVH
`define OMC_REGS_SVH

// Mode control encodings carried in the 3-bit mode_code field
`define OMC_MODE_CTRL_ADDR 8'h01
`define OMC_MC_SLEEP 3'h1
`define OMC_MC_STANDBY 3'h4
`define OMC_MC_NORMAL 3'h7

// Clock rate in MHz (50 ns period)
`define OMC_CLK_MHZ 20

// Start-up delay after power-on; least time, rounds up
`define OMC_STARTUP_TIME_US 1000
`define OMC_STARTUP_CYCLES ((`OMC_STARTUP_TIME_US * `OMC_CLK_MHZ) + 0)
`define OMC_STARTUP_W 16

// Supply undervoltage detection time; "longer than", so a least time
`define OMC_UV_DET_TIME_US 10
`define OMC_UV_DET_CYCLES (`OMC_UV_DET_TIME_US * `OMC_CLK_MHZ)
`define OMC_UV_W 8

// Reset values of the configuration bits
`define OMC_RST_CAN_WAKE_EN 1'h1
`define OMC_RST_WAKE_FALL_EN 1'h1
`define OMC_RST_WAKE_RISE_EN 1'h1
`define OMC_RST_SEL_WAKE_EN 1'h0
`define OMC_RST_SPI_FAULT_EN 1'h0
`define OMC_RST_OTW_IRQ_EN 1'h0

`endif

/* File: design/omc_pkg.sv */
package omc_pkg;

    typedef enum logic [2:0] {
        MODE_OFF,
        MODE_STANDBY,
        MODE_NORMAL,
        MODE_SLEEP,
        MODE_OVERTEMP
    } omc_mode_t;

    typedef struct packed {
        logic can_wake_enable;
        logic wake_pin_falling_enable;
        logic wake_pin_rising_enable;
        logic selective_wake_enable;
        logic spi_fault_detect_enable;
        logic overheat_warning_irq_enable;
    } omc_cfg_t;

    typedef struct packed {
        logic forced_sleep_flag;
        logic overheat_warning_state;
        logic first_normal_pending;
    } omc_status_t;

    typedef struct packed {
        logic can_bus_wake;
        logic selective_wake;
        logic wake_pin_rise;
        logic wake_pin_fall;
        logic irq_event;
    } omc_events_t;

endpackage

/* File: design/omc_uv_filter.sv */
`timescale 1ns/100ps
`include "omc_regs.svh"

module omc_uv_filter (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_low,
    output logic o_uv
);

    logic [`OMC_UV_W-1:0] cnt_ff;
    logic uv_ff;
    logic [`OMC_UV_W-1:0] nxt_cnt;
    logic nxt_uv;
    wire logic limit_hit;

    // Detected only once the supply stayed low past the detection time
    assign limit_hit = (cnt_ff == `OMC_UV_W'(`OMC_UV_DET_CYCLES));
    assign nxt_cnt = !i_low ? '0 : (limit_hit ? cnt_ff : cnt_ff + `OMC_UV_W'(1));
    assign nxt_uv = i_low & limit_hit;
    assign o_uv = uv_ff;

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            cnt_ff <= '0;
            uv_ff <= 1'b0;
        end else begin
            cnt_ff <= nxt_cnt;
            uv_ff <= nxt_uv;
        end
    end

endmodule

/* File: design/omc_startup_timer.sv */
`timescale 1ns/100ps
`include "omc_regs.svh"

module omc_startup_timer (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_run,
    input wire logic [`OMC_STARTUP_W-1:0] i_limit,
    output logic o_done
);

    logic [`OMC_STARTUP_W-1:0] cnt_ff;
    logic [`OMC_STARTUP_W-1:0] nxt_cnt;
    wire logic at_limit;

    // Restarts whenever the run condition drops, e.g. battery sagging again
    assign at_limit = (cnt_ff >= i_limit);
    assign nxt_cnt = !i_run ? '0 : (at_limit ? cnt_ff : cnt_ff + `OMC_STARTUP_W'(1));
    assign o_done = i_run & at_limit;

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            cnt_ff <= '0;
        end else begin
            cnt_ff <= nxt_cnt;
        end
    end

endmodule

/* File: design/omc_mode_ctrl.sv */
`timescale 1ns/100ps
`include "omc_regs.svh"


module omc_mode_ctrl #(
    parameter logic [`OMC_STARTUP_W-1:0] STARTUP_CYCLES = `OMC_STARTUP_W'(`OMC_STARTUP_CYCLES)
) (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_bat_above_pon,
    input wire logic i_bat_below_poff,
    input wire logic i_vcc_low,
    input wire logic i_vio_low,
    input wire logic i_vio_valid,
    input wire logic i_temp_above_act,
    input wire logic i_temp_below_rel,
    input wire logic i_temp_above_warn,
    input wire logic i_mode_wr,
    input wire logic [2:0] i_mode_code,
    input wire logic i_spi_cmd,
    input wire omc_pkg::omc_events_t i_events,
    input wire logic i_selective_config_valid,
    input wire logic i_wake_clear,
    input wire logic i_warn_clear,
    input wire logic i_cfg_wr,
    input wire omc_pkg::omc_cfg_t i_cfg,
    output omc_pkg::omc_mode_t o_mode,
    output omc_pkg::omc_cfg_t o_cfg,
    output omc_pkg::omc_status_t o_status,
    output logic o_overheat_warning_event,
    output logic o_wake_pending,
    output logic o_receive_data_low,
    output logic o_regulator_inhibit_out,
    output logic o_regulator_inhibit_oe,
    output logic o_can_pins_oe,
    output logic o_can_trx_enable,
    output logic o_bus_monitor_enable,
    output logic o_selective_wake_active,
    output logic o_spi_active
);

    omc_pkg::omc_mode_t mode_ff;
    omc_pkg::omc_mode_t nxt_mode;
    omc_pkg::omc_cfg_t cfg_ff;
    omc_pkg::omc_cfg_t nxt_cfg;
    logic pending_ff;
    logic nxt_pending;
    logic forced_sleep_ff;
    logic nxt_forced_sleep;
    logic warn_state_ff;
    logic warn_event_ff;
    logic nxt_warn_event;
    logic first_normal_ff;
    logic nxt_first_normal;

    wire logic vcc_uv;
    wire logic vio_uv;
    wire logic supply_uv;
    wire logic startup_done;
    wire logic in_off;
    wire logic in_standby;
    wire logic in_normal;
    wire logic in_sleep;
    wire logic in_overtemp;
    wire logic wr_normal;
    wire logic wr_standby;
    wire logic wr_sleep;
    wire logic sleep_ok;
    wire logic sleep_refused;
    wire logic refusal_flag;
    wire logic detect_on;
    wire logic sel_active;
    wire logic bus_wake;
    wire logic pin_wake;
    wire logic new_wake;
    wire logic sleep_wake;
    wire logic force_sleep;
    wire logic cmd_sleep;
    wire logic warn_rise;
    wire logic sleep_blocked;

    omc_uv_filter u_vcc_uv (
        .i_clk(i_clk),
        .i_rst_b(i_rst_b),
        .i_low(i_vcc_low),
        .o_uv(vcc_uv)
    );

    omc_uv_filter u_vio_uv (
        .i_clk(i_clk),
        .i_rst_b(i_rst_b),
        .i_low(i_vio_low),
        .o_uv(vio_uv)
    );

    // Counts only while powering up from Off
    omc_startup_timer u_startup (
        .i_clk(i_clk),
        .i_rst_b(i_rst_b),
        .i_run(in_off & i_bat_above_pon & ~i_bat_below_poff),
        .i_limit(STARTUP_CYCLES),
        .o_done(startup_done)
    );

    assign in_off = (mode_ff == omc_pkg::MODE_OFF);
    assign in_standby = (mode_ff == omc_pkg::MODE_STANDBY);
    assign in_normal = (mode_ff == omc_pkg::MODE_NORMAL);
    assign in_sleep = (mode_ff == omc_pkg::MODE_SLEEP);
    assign in_overtemp = (mode_ff == omc_pkg::MODE_OVERTEMP);

    // Codes other than the three known ones decode to nothing
    assign wr_normal = i_mode_wr & (i_mode_code == `OMC_MC_NORMAL);
    assign wr_standby = i_mode_wr & (i_mode_code == `OMC_MC_STANDBY);
    assign wr_sleep = i_mode_wr & (i_mode_code == `OMC_MC_SLEEP);

    assign supply_uv = vcc_uv | vio_uv;

    // Wake detection; none in Off or Overtemp
    assign detect_on = in_standby | in_normal | in_sleep;
    assign sel_active = cfg_ff.selective_wake_enable & i_selective_config_valid;
    assign bus_wake = cfg_ff.can_wake_enable &
        (sel_active ? i_events.selective_wake : i_events.can_bus_wake);
    assign pin_wake = (cfg_ff.wake_pin_rising_enable & i_events.wake_pin_rise) |
        (cfg_ff.wake_pin_falling_enable & i_events.wake_pin_fall);
    assign new_wake = detect_on & (bus_wake | pin_wake | i_events.irq_event);

    // Sleep request check also refuses on a wake event arriving in the same cycle
    assign sleep_ok = ~pending_ff & ~new_wake &
        (cfg_ff.can_wake_enable | cfg_ff.wake_pin_falling_enable |
        cfg_ff.wake_pin_rising_enable);
    // Battery loss or overtemp wins the mode, so Sleep side effects must not apply
    assign sleep_blocked = i_bat_below_poff | (in_normal & i_temp_above_act);
    assign cmd_sleep = wr_sleep & (in_normal | in_standby) & sleep_ok & ~sleep_blocked;
    assign sleep_refused = wr_sleep & (in_normal | in_standby) & ~sleep_ok;
    assign refusal_flag = sleep_refused & cfg_ff.spi_fault_detect_enable;
    assign force_sleep = supply_uv & (in_normal | in_standby) & ~sleep_blocked;

    // An SPI command counts as a wake only with a valid I/O supply
    assign sleep_wake = new_wake | pending_ff | (i_spi_cmd & i_vio_valid);

    always_comb begin
        nxt_mode = mode_ff;
        case (mode_ff)
            omc_pkg::MODE_OFF: begin
                if (startup_done) begin
                    nxt_mode = omc_pkg::MODE_STANDBY;
                end
            end
            omc_pkg::MODE_NORMAL: begin
                if (i_temp_above_act) begin
                    nxt_mode = omc_pkg::MODE_OVERTEMP;
                end else if (force_sleep | cmd_sleep) begin
                    nxt_mode = omc_pkg::MODE_SLEEP;
                end else if (wr_standby | sleep_refused) begin
                    nxt_mode = omc_pkg::MODE_STANDBY;
                end
            end
            omc_pkg::MODE_STANDBY: begin
                if (force_sleep | cmd_sleep) begin
                    nxt_mode = omc_pkg::MODE_SLEEP;
                end else if (wr_normal) begin
                    nxt_mode = omc_pkg::MODE_NORMAL;
                end
            end
            omc_pkg::MODE_SLEEP: begin
                if (wr_normal) begin
                    nxt_mode = omc_pkg::MODE_NORMAL;
                end else if (wr_standby | sleep_wake) begin
                    nxt_mode = omc_pkg::MODE_STANDBY;
                end
            end
            omc_pkg::MODE_OVERTEMP: begin
                if (i_temp_below_rel) begin
                    nxt_mode = omc_pkg::MODE_STANDBY;
                end
            end
            default: begin
                nxt_mode = omc_pkg::MODE_OFF;
            end
        endcase
        // Battery loss overrides everything
        if (i_bat_below_poff) begin
            nxt_mode = omc_pkg::MODE_OFF;
        end
    end

    // Pending wake: new events win over the host clear
    always_comb begin
        nxt_pending = pending_ff;
        if (i_wake_clear) begin
            nxt_pending = 1'b0;
        end
        if (new_wake | refusal_flag) begin
            nxt_pending = 1'b1;
        end
        if (force_sleep | i_bat_below_poff | in_off) begin
            nxt_pending = 1'b0;
        end
    end

    // Forced Sleep rewrites wake sources so the node cannot deadlock asleep
    always_comb begin
        nxt_cfg = cfg_ff;
        if (i_cfg_wr) begin
            nxt_cfg = i_cfg;
        end
        if (force_sleep) begin
            nxt_cfg.can_wake_enable = 1'b1;
            nxt_cfg.wake_pin_falling_enable = 1'b1;
            nxt_cfg.wake_pin_rising_enable = 1'b1;
            nxt_cfg.selective_wake_enable = 1'b0;
        end
    end

    assign nxt_forced_sleep = force_sleep ? 1'b1 :
        (cmd_sleep ? 1'b0 : forced_sleep_ff);

    assign nxt_first_normal = first_normal_ff & (nxt_mode != omc_pkg::MODE_NORMAL);

    // Overheat event is sticky; a new warning edge wins over clear
    assign warn_rise = i_temp_above_warn & ~warn_state_ff;
    assign nxt_warn_event = (warn_rise & cfg_ff.overheat_warning_irq_enable) |
        (warn_event_ff & ~i_warn_clear);

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            mode_ff <= omc_pkg::MODE_OFF;
            pending_ff <= 1'b0;
            forced_sleep_ff <= 1'b0;
            warn_state_ff <= 1'b0;
            warn_event_ff <= 1'b0;
            first_normal_ff <= 1'b1;
        end else begin
            mode_ff <= nxt_mode;
            pending_ff <= nxt_pending;
            forced_sleep_ff <= nxt_forced_sleep;
            warn_state_ff <= i_temp_above_warn;
            warn_event_ff <= nxt_warn_event;
            first_normal_ff <= nxt_first_normal;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            cfg_ff.can_wake_enable <= `OMC_RST_CAN_WAKE_EN;
            cfg_ff.wake_pin_falling_enable <= `OMC_RST_WAKE_FALL_EN;
            cfg_ff.wake_pin_rising_enable <= `OMC_RST_WAKE_RISE_EN;
            cfg_ff.selective_wake_enable <= `OMC_RST_SEL_WAKE_EN;
            cfg_ff.spi_fault_detect_enable <= `OMC_RST_SPI_FAULT_EN;
            cfg_ff.overheat_warning_irq_enable <= `OMC_RST_OTW_IRQ_EN;
        end else begin
            cfg_ff <= nxt_cfg;
        end
    end

    assign o_mode = mode_ff;
    assign o_cfg = cfg_ff;
    assign o_status.forced_sleep_flag = forced_sleep_ff;
    assign o_status.overheat_warning_state = warn_state_ff;
    assign o_status.first_normal_pending = first_normal_ff;
    assign o_overheat_warning_event = warn_event_ff;
    assign o_wake_pending = pending_ff;

    // Pending wake holds receive data low in every powered mode
    assign o_receive_data_low = pending_ff & ~in_off;

    // Inhibit driven high in Standby, Normal, Overtemp; floating in Sleep and Off
    assign o_regulator_inhibit_oe = in_standby | in_normal | in_overtemp;
    assign o_regulator_inhibit_out = o_regulator_inhibit_oe;

    // Transmit and receive only in Normal; CAN pins float in Off and Overtemp
    assign o_can_trx_enable = in_normal;
    assign o_can_pins_oe = ~(in_off | in_overtemp);
    assign o_bus_monitor_enable = detect_on & cfg_ff.can_wake_enable;
    assign o_selective_wake_active = sel_active;
    assign o_spi_active = in_standby | in_normal | (in_sleep & i_vio_valid);

endmodule

/* File: sim/omc_host_model.sv */
`timescale 1ns/100ps

module omc_host_model (
    input wire logic i_clk,
    output logic o_mode_wr,
    output logic [2:0] o_mode_code,
    output logic o_spi_cmd,
    output logic o_cfg_wr,
    output omc_pkg::omc_cfg_t o_cfg,
    output logic [2:0] o_pulse
);
    // Mode and config writes and the bare command count as commands; the two clear pulses do not
    assign o_spi_cmd = o_mode_wr | o_cfg_wr | o_pulse[2];

    initial begin
        o_mode_wr = 1'h0;
        o_mode_code = 3'h0;
        o_cfg_wr = 1'h0;
        o_cfg = 6'h00;
        o_pulse = 3'h0;
    end

    // Mode field of the control register; data inverted once strobe drops
    task wr_mode(input logic [2:0] c);
        @(posedge i_clk);
        o_mode_wr <= 1'h1;
        o_mode_code <= c;
        @(posedge i_clk);
        o_mode_wr <= 1'h0;
        o_mode_code <= ~c;
        #1;
    endtask

    task wr_cfg(input omc_pkg::omc_cfg_t v);
        @(posedge i_clk);
        o_cfg_wr <= 1'h1;
        o_cfg <= v;
        @(posedge i_clk);
        o_cfg_wr <= 1'h0;
        o_cfg <= ~v;
        #1;
    endtask

    // Bit 0 wake clear, bit 1 warning clear, bit 2 bare command
    task poke(input logic [2:0] p);
        @(posedge i_clk);
        o_pulse <= p;
        @(posedge i_clk);
        o_pulse <= 3'h0;
        #1;
    endtask
endmodule

/* File: sim/omc_mode_ctrl_properties.sv */
`timescale 1ns/100ps

module omc_mode_ctrl_props (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_bat_below_poff,
    input wire logic i_temp_above_act,
    input wire logic i_temp_below_rel,
    input wire logic i_temp_above_warn,
    input wire logic i_mode_wr,
    input wire logic [2:0] i_mode_code,
    input wire omc_pkg::omc_mode_t o_mode,
    input wire omc_pkg::omc_cfg_t o_cfg,
    input wire omc_pkg::omc_status_t o_status,
    input wire logic o_wake_pending,
    input wire logic o_receive_data_low,
    input wire logic o_regulator_inhibit_oe,
    input wire logic o_can_pins_oe,
    input wire logic o_can_trx_enable
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);

    wire awake = o_mode == omc_pkg::MODE_NORMAL || o_mode == omc_pkg::MODE_STANDBY;
    wire ok_bat = !i_bat_below_poff;

    // Flag set on the new Sleep can only come from undervoltage
    sequence s_uv_sleep;
        awake ##1 (o_mode == omc_pkg::MODE_SLEEP && o_status.forced_sleep_flag);
    endsequence
    sequence s_cmd_sleep;
        awake && i_mode_wr && i_mode_code == 3'h1 ##1 o_mode == omc_pkg::MODE_SLEEP;
    endsequence

    a_poff_off: assert property (
        i_bat_below_poff |=> o_mode == omc_pkg::MODE_OFF)
        else $error("mode not off after battery loss");
    a_sleep_normal: assert property (
        o_mode == omc_pkg::MODE_SLEEP && i_mode_wr && i_mode_code == 3'h7 && ok_bat
        |=> o_mode == omc_pkg::MODE_NORMAL)
        else $error("normal code ignored in sleep");
    a_hot_entry: assert property (
        o_mode == omc_pkg::MODE_NORMAL && i_temp_above_act && ok_bat
        |=> o_mode == omc_pkg::MODE_OVERTEMP)
        else $error("overtemp not entered");
    a_hot_exit: assert property (
        o_mode == omc_pkg::MODE_OVERTEMP && i_temp_below_rel && ok_bat
        |=> o_mode == omc_pkg::MODE_STANDBY)
        else $error("overtemp not left");
    a_inhibit_modes: assert property (
        o_regulator_inhibit_oe == (o_mode inside {omc_pkg::MODE_STANDBY,
            omc_pkg::MODE_NORMAL, omc_pkg::MODE_OVERTEMP}))
        else $error("inhibit drive wrong for mode");
    a_can_floats: assert property (
        o_mode inside {omc_pkg::MODE_OFF, omc_pkg::MODE_OVERTEMP}
        |-> !o_can_pins_oe && !o_can_trx_enable)
        else $error("can pins driven");
    a_rxd_pending: assert property (
        o_receive_data_low == (o_wake_pending && o_mode != omc_pkg::MODE_OFF))
        else $error("receive data low mismatch");
    a_first_normal: assert property (
        o_mode == omc_pkg::MODE_NORMAL |-> !o_status.first_normal_pending)
        else $error("first normal flag still set");
    a_warn_state: assert property (
        1'b1 |=> o_status.overheat_warning_state == $past(i_temp_above_warn))
        else $error("warning state not following temperature");
    a_uv_defaults: assert property (
        s_uv_sleep |-> o_cfg.can_wake_enable && o_cfg.wake_pin_falling_enable
        && o_cfg.wake_pin_rising_enable && !o_cfg.selective_wake_enable && !o_wake_pending)
        else $error("forced sleep config wrong");
    a_cmd_sleep_flag: assert property (
        s_cmd_sleep |-> !o_status.forced_sleep_flag)
        else $error("commanded sleep marked forced");
endmodule

bind omc_mode_ctrl omc_mode_ctrl_props chk_u (.*);

/* File: sim/tb.sv */
`timescale 1ns/100ps

module tb;
    logic clk, rst_b, pon, poff, vcc_low, vio_low, vio_valid, t_act, t_rel, t_warn, cfg_valid;
    logic mode_wr, spi_cmd, cfg_wr, owe, pend, rxl, regulator_inhibit_out, inh_oe, can_oe, trx, mon, sel_act, spi_act;
    logic [2:0] code, clr;
    logic [2:0] bad [5] = '{3'h0, 3'h2, 3'h3, 3'h5, 3'h6};
    omc_pkg::omc_events_t ev;
    omc_pkg::omc_cfg_t cfg_in, cfg_o;
    omc_pkg::omc_mode_t mode;
    omc_pkg::omc_status_t st;
    int num_errors, compares, n;

    omc_host_model host_u (.i_clk(clk), .o_mode_wr(mode_wr), .o_mode_code(code),
        .o_spi_cmd(spi_cmd), .o_cfg_wr(cfg_wr), .o_cfg(cfg_in), .o_pulse(clr));

    // Short boot count keeps the run small
    omc_mode_ctrl #(.STARTUP_CYCLES(16'h0014)) dut_u (
        .i_clk(clk), .i_rst_b(rst_b), .i_bat_above_pon(pon), .i_bat_below_poff(poff),
        .i_vcc_low(vcc_low), .i_vio_low(vio_low), .i_vio_valid(vio_valid),
        .i_temp_above_act(t_act), .i_temp_below_rel(t_rel), .i_temp_above_warn(t_warn),
        .i_mode_wr(mode_wr), .i_mode_code(code), .i_spi_cmd(spi_cmd), .i_events(ev),
        .i_selective_config_valid(cfg_valid), .i_wake_clear(clr[0]), .i_warn_clear(clr[1]),
        .i_cfg_wr(cfg_wr), .i_cfg(cfg_in), .o_mode(mode), .o_cfg(cfg_o), .o_status(st),
        .o_overheat_warning_event(owe), .o_wake_pending(pend), .o_receive_data_low(rxl),
        .o_regulator_inhibit_out(regulator_inhibit_out), .o_regulator_inhibit_oe(inh_oe),
        .o_can_pins_oe(can_oe), .o_can_trx_enable(trx), .o_bus_monitor_enable(mon),
        .o_selective_wake_active(sel_act), .o_spi_active(spi_act));

    task chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value %s exp %h seen %h", nm, exp, seen);
        end
    endtask

    task close_out;
        if (num_errors == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task tick(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask

    task wait_mode(input omc_pkg::omc_mode_t m);
        n = 0;
        while (mode !== m && n < 400) begin
            tick(1);
            n++;
        end
        if (mode !== m) begin
            num_errors++;
            close_out();
        end
    endtask

    task pulse_ev(input omc_pkg::omc_events_t e);
        @(posedge clk);
        ev <= e;
        @(posedge clk);
        ev <= 5'h00;
        tick(1);
    endtask

    initial begin
        clk = 1'h0;
        forever #25 clk = ~clk;
    end

    initial begin
        {rst_b, pon, poff, vcc_low, vio_low, vio_valid, t_act, t_rel, t_warn} = 9'h000;
        cfg_valid = 1'h0;
        ev = 5'h00;
        num_errors = 0;
        compares = 0;
        repeat (16) @(posedge clk);
        rst_b <= 1'h1;
        tick(1);
        chk("mode", mode, omc_pkg::MODE_OFF);
        chk("nms", st.first_normal_pending, 1'h1);
        chk("inh", inh_oe, 1'h0);
        @(posedge clk) pon <= 1'h1;
        wait_mode(omc_pkg::MODE_STANDBY);
        chk("boot", n >= 20, 1'h1);
        chk("stby", {inh_oe, regulator_inhibit_out, trx, mon, spi_act}, 5'h1b);
        host_u.wr_mode(3'h7);
        chk("mode", mode, omc_pkg::MODE_NORMAL);
        chk("nms", {trx, st.first_normal_pending}, 2'h2);
        foreach (bad[i]) begin
            host_u.wr_mode(bad[i]);
            chk("ign", mode, omc_pkg::MODE_NORMAL);
        end
        host_u.wr_mode(3'h1);
        chk("mode", mode, omc_pkg::MODE_SLEEP);
        chk("slp", {inh_oe, st.forced_sleep_flag}, 2'h0);
        host_u.poke(3'h4);
        chk("slp", {mode, spi_act}, {omc_pkg::MODE_SLEEP, 1'h0});
        host_u.wr_mode(3'h7);
        chk("mode", mode, omc_pkg::MODE_NORMAL);
        host_u.wr_mode(3'h4);
        chk("mode", mode, omc_pkg::MODE_STANDBY);
        host_u.wr_mode(3'h1);
        host_u.wr_mode(3'h4);
        chk("mode", mode, omc_pkg::MODE_STANDBY);
        host_u.wr_mode(3'h1);
        pulse_ev(5'h02);
        chk("mode", mode, omc_pkg::MODE_STANDBY);
        chk("rxd", rxl, 1'h1);
        host_u.wr_mode(3'h1);
        chk("mode", mode, omc_pkg::MODE_STANDBY);
        host_u.poke(3'h1);
        chk("rxd", rxl, 1'h0);
        // No wake source left, fault signalling on
        host_u.wr_cfg(6'h02);
        host_u.wr_mode(3'h1);
        chk("mode", mode, omc_pkg::MODE_STANDBY);
        chk("rxd", rxl, 1'h1);
        host_u.poke(3'h1);
        host_u.wr_cfg(6'h38);
        @(posedge clk) vio_valid <= 1'h1;
        host_u.wr_mode(3'h1);
        chk("slp", {mode, spi_act}, {omc_pkg::MODE_SLEEP, 1'h1});
        host_u.poke(3'h4);
        tick(1);
        chk("mode", mode, omc_pkg::MODE_STANDBY);
        host_u.wr_cfg(6'h3c);
        @(posedge clk) cfg_valid <= 1'h1;
        pulse_ev(5'h10);
        chk("sel", {sel_act, pend}, 2'h2);
        pulse_ev(5'h08);
        chk("pend", pend, 1'h1);
        host_u.poke(3'h1);
        @(posedge clk) cfg_valid <= 1'h0;
        pulse_ev(5'h10);
        chk("std", {sel_act, pend}, 2'h1);
        host_u.wr_mode(3'h7);
        @(posedge clk) t_act <= 1'h1;
        @(posedge clk) t_act <= 1'h0;
        #1;
        chk("mode", mode, omc_pkg::MODE_OVERTEMP);
        chk("hot", {rxl, spi_act}, 2'h2);
        host_u.poke(3'h1);
        pulse_ev(5'h01);
        chk("hot", {can_oe, pend}, 2'h0);
        @(posedge clk) t_rel <= 1'h1;
        @(posedge clk) t_rel <= 1'h0;
        #1;
        chk("mode", mode, omc_pkg::MODE_STANDBY);
        host_u.wr_cfg(6'h39);
        @(posedge clk) t_warn <= 1'h1;
        tick(2);
        chk("warn", {st.overheat_warning_state, owe}, 2'h3);
        host_u.poke(3'h2);
        chk("warn", owe, 1'h0);
        @(posedge clk) t_warn <= 1'h0;
        host_u.wr_cfg(6'h38);
        @(posedge clk) t_warn <= 1'h1;
        tick(2);
        chk("warn", {st.overheat_warning_state, owe}, 2'h2);
        @(posedge clk) t_warn <= 1'h0;
        host_u.wr_mode(3'h7);
        pulse_ev(5'h01);
        host_u.wr_cfg(6'h04);
        @(posedge clk) vcc_low <= 1'h1;
        wait_mode(omc_pkg::MODE_SLEEP);
        chk("uv", n >= 200, 1'h1);
        chk("uv", {cfg_o, pend, st.forced_sleep_flag}, 8'he1);
        @(posedge clk) vcc_low <= 1'h0;
        @(posedge clk) poff <= 1'h1;
        @(posedge clk) poff <= 1'h0;
        #1;
        chk("off", {mode, inh_oe, can_oe}, 5'h00);
        wait_mode(omc_pkg::MODE_STANDBY);
        host_u.wr_mode(3'h1);
        chk("cmd", {mode, st.forced_sleep_flag}, {omc_pkg::MODE_SLEEP, 1'h0});
        host_u.wr_mode(3'h7);
        @(posedge clk) vio_low <= 1'h1;
        wait_mode(omc_pkg::MODE_SLEEP);
        chk("vio", {n >= 200, st.forced_sleep_flag}, 2'h3);
        @(posedge clk) rst_b <= 1'h0;
        @(posedge clk) rst_b <= 1'h1;
        tick(1);
        chk("rst", {mode, st.first_normal_pending}, {omc_pkg::MODE_OFF, 1'h1});
        close_out();
    end
endmodule
